// file: baud_tick_gen.sv
// fractional baud rate divider producing a one-cycle enable
`timescale 1ns/1ns
module baud_tick_gen
  import uart_flags_pkg::*;
#(
  parameter int WHOLE_W = whole_width,
  parameter int FRAC_W = fraction_width
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WHOLE_W-1:0] divisor_whole,
  input wire logic [FRAC_W-1:0] divisor_fraction,
  output logic tick
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [WHOLE_W-1:0] count;
    logic [FRAC_W-1:0] acc;
    logic tick;
  } baud_state_type;

  localparam logic [WHOLE_W-1:0] count_zero = '0;
  localparam logic [WHOLE_W-1:0] count_one = WHOLE_W'(1);
  localparam logic [FRAC_W-1:0] acc_zero = '0;

  baud_state_type s;
  baud_state_type next_s;
  logic [FRAC_W:0] sum;

  // period is whole cycles plus one extra whenever the fraction carries;
  // a zero divisor ticks at once so a leftover count cannot stall it
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    sum = {1'b0, s.acc} + {1'b0, divisor_fraction};
    if (s.count == count_zero || divisor_whole == count_zero) begin
      next_s.tick = 1'b1;
      if (divisor_whole == count_zero) begin
        // zero divisor is ignored: every cycle ticks, ratio of one
        next_s.count = count_zero; // RQ10
        next_s.acc = acc_zero; // RQ10
      end else begin
        next_s.acc = sum[FRAC_W-1:0];
        next_s.count = divisor_whole - count_one +
          {{(WHOLE_W-1){1'b0}}, sum[FRAC_W]};
      end
    end else begin
      next_s.count = s.count - count_one;
    end
  end

  // register the divider state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule : baud_tick_gen

// file: serial_side_model.sv
// stand-in for the queues and shifters feeding occupancy and activity
`timescale 1ns/1ns
module serial_side_model
  import uart_flags_pkg::*;
#(
  parameter int LEVEL_W = 5
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [LEVEL_W-1:0] set_tx,
  input wire logic [LEVEL_W-1:0] set_rx,
  input wire logic set_shift,
  input wire logic set_rxc,
  output logic [LEVEL_W-1:0] tx_level,
  output logic [LEVEL_W-1:0] rx_level,
  output logic tx_shift_active,
  output logic rx_char_active
);
  // lines move only on an edge, as real queue logic would
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_level <= '0;
      rx_level <= '0;
      tx_shift_active <= 1'b0;
      rx_char_active <= 1'b0;
    end else begin
      tx_level <= set_tx;
      rx_level <= set_rx;
      tx_shift_active <= set_shift;
      rx_char_active <= set_rxc;
    end
  end
endmodule : serial_side_model

// file: uart_flags_and_baud_divisor.sv
// flag register, baud divisor registers and divider behind axi4-lite
//
// How it works
// RQ1: after reset transmit-full, receive-full and busy read 0, both empties 1.
// RQ2: bit 7 shows an empty transmit holding register or empty transmit queue.
// RQ3: bit 6 shows a full receive holding register or full receive queue.
// RQ4: bit 5 shows a full transmit holding register or full transmit queue.
// RQ5: bit 4 shows an empty receive holding register or empty receive queue.
// RQ6: bit 3 stays high until the whole character and its stop bits are out.
// RQ7: busy rises once the transmit queue holds anything, enabled or not.
// RQ8: the whole divisor is a 16-bit read-write field, cleared on reset.
// RQ9: the fraction divisor is a 6-bit read-write field, cleared on reset.
// RQ10: a zero whole divisor is ignored and the divider runs at ratio one.
// RQ11: new divisor values wait until no character is moving either way.
// RQ12: divisor values are taken over only by a line-control write.
// RQ13: reserved bits carry no state and software should leave them alone.
// RQ14: line-control bit 4 picks queue mode, else one-byte holding registers.
// RQ15: flags track occupancy on every read and writes to them do nothing.
`timescale 1ns/1ns
module uart_flags_and_baud_divisor
  import uart_flags_pkg::*;
#(
  parameter int QUEUE_DEPTH = default_queue_depth,
  parameter int LEVEL_W = $clog2(QUEUE_DEPTH + 1)
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [LEVEL_W-1:0] tx_level,
  input wire logic [LEVEL_W-1:0] rx_level,
  input wire logic tx_shift_active,
  input wire logic rx_char_active,
  output logic queue_enable,
  output logic line_control_strobe,
  output logic [15:0] divisor_whole_active,
  output logic [5:0] divisor_fraction_active,
  output logic baud_tick
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [11:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] divisor_whole;
    logic [5:0] divisor_fraction;
    logic queue_enable;
    logic pending;
    logic [15:0] whole_active;
    logic [5:0] fraction_active;
    logic strobe;
    logic tx_empty;
    logic rx_full;
    logic tx_full;
    logic rx_empty;
    logic busy;
  } flags_state_type;

  localparam logic [LEVEL_W-1:0] level_zero = '0;
  localparam logic [LEVEL_W-1:0] level_depth = LEVEL_W'(QUEUE_DEPTH);
  localparam logic [LEVEL_W-1:0] level_one = LEVEL_W'(1);

  flags_state_type s;
  flags_state_type next_s;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // true when the address names one of the mapped words
  function automatic logic known_address(input logic [11:0] addr);
    known_address = (addr == line_flags_offset) ||
      (addr == divisor_whole_offset) ||
      (addr == divisor_fraction_offset) ||
      (addr == line_control_offset);
  endfunction : known_address

  // byte lane merge of a write into a 32-bit view of a register
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] merged;
    merged = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merged[i*byte_width +: byte_width] =
          data[i*byte_width +: byte_width];
      end
    end
    lane_merge = merged;
  endfunction : lane_merge

  // full level depends on the mode: queue depth or one holding byte
  function automatic logic level_full(input logic [LEVEL_W-1:0] level,
      input logic fifo_mode);
    if (fifo_mode) begin
      level_full = (level >= level_depth);
    end else begin
      level_full = (level >= level_one);
    end
  endfunction : level_full

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic [31:0] merged;
  logic [31:0] read_word;
  logic idle_line;

  always_comb begin
    next_s = s;
    merged = read_zero;
    read_word = read_zero;
    next_s.strobe = 1'b0;
    idle_line = !tx_shift_active && !rx_char_active;

    // flags refresh every cycle from occupancy and transmitter state
    next_s.tx_empty = (tx_level == level_zero); // RQ2
    next_s.rx_full = level_full(rx_level, s.queue_enable); // RQ3 RQ14
    next_s.tx_full = level_full(tx_level, s.queue_enable); // RQ4 RQ14
    next_s.rx_empty = (rx_level == level_zero); // RQ5
    // busy covers queued bytes and the shifter up to the last stop bit
    next_s.busy = (tx_level != level_zero) || tx_shift_active; // RQ6 RQ7

    // write address and data may arrive in either order
    if (awvalid && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.waddr = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata = wdata;
      next_s.wstrb = wstrb;
    end
    if (bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end

    // pending divisors move over only while no character is in flight
    if (s.pending && idle_line) begin
      next_s.whole_active = s.divisor_whole; // RQ11
      next_s.fraction_active = s.divisor_fraction; // RQ11
      next_s.pending = 1'b0; // RQ11
    end

    // perform the write once both halves are held
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = resp_okay;
      if (s.waddr[1:0] != word_align_bits ||
          !known_address(s.waddr)) begin
        next_s.bresp = resp_slverr;
      end else begin
        unique case (s.waddr)
          divisor_whole_offset: begin
            merged = lane_merge({16'h0000, s.divisor_whole},
              s.wdata, s.wstrb);
            next_s.divisor_whole = merged[whole_width-1:0]; // RQ8
          end
          divisor_fraction_offset: begin
            merged = lane_merge({26'h0000000, s.divisor_fraction},
              s.wdata, s.wstrb);
            next_s.divisor_fraction = merged[fraction_width-1:0]; // RQ9
          end
          line_control_offset: begin
            if (s.wstrb[0]) begin
              next_s.queue_enable = s.wdata[queue_enable_bit]; // RQ14
            end
            // the strobe arms the divisor hand-over; it wins over apply
            next_s.strobe = 1'b1; // RQ12
            next_s.pending = 1'b1; // RQ12
          end
          // flag register ignores writes, answered okay
          default: begin
            next_s.bresp = resp_okay; // RQ15
          end
        endcase
      end
    end

    // channel readies drop while a half is held or a response waits
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready = !next_s.w_held && !next_s.bvalid;

    // read path: one read under way, answered the next cycle
    if (rvalid && rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
    if (arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = resp_okay;
      // reserved bits read zero, no state behind them
      read_word = read_zero; // RQ13
      if (araddr[1:0] != word_align_bits || !known_address(araddr)) begin
        next_s.rresp = resp_slverr;
      end else begin
        unique case (araddr)
          line_flags_offset: begin
            read_word[tx_empty_bit] = s.tx_empty; // RQ15
            read_word[rx_full_bit] = s.rx_full; // RQ15
            read_word[tx_full_bit] = s.tx_full; // RQ15
            read_word[rx_empty_bit] = s.rx_empty; // RQ15
            read_word[busy_bit] = s.busy; // RQ15
          end
          divisor_whole_offset: begin
            read_word[whole_width-1:0] = s.divisor_whole; // RQ8
          end
          divisor_fraction_offset: begin
            read_word[fraction_width-1:0] = s.divisor_fraction; // RQ9
          end
          default: begin
            read_word[queue_enable_bit] = s.queue_enable;
          end
        endcase
      end
      next_s.rdata = read_word;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // control state takes constants only under reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.bresp <= resp_okay;
      s.rresp <= resp_okay;
      s.divisor_whole <= divisor_whole_reset; // RQ8
      s.divisor_fraction <= divisor_fraction_reset; // RQ9
      s.whole_active <= divisor_whole_reset;
      s.fraction_active <= divisor_fraction_reset;
      s.queue_enable <= queue_enable_reset;
      s.tx_empty <= tx_empty_reset; // RQ1
      s.rx_full <= rx_full_reset; // RQ1
      s.tx_full <= tx_full_reset; // RQ1
      s.rx_empty <= rx_empty_reset; // RQ1
      s.busy <= busy_reset; // RQ1
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // divider on the applied divisor values
  // ---------------------------------------------------------------
  // runs from the applied copy so a mid-character write cannot glitch it
  baud_tick_gen #(
    .WHOLE_W(whole_width),
    .FRAC_W(fraction_width)
  ) divider (
    .clk(clk),
    .rstn(rstn),
    .divisor_whole(s.whole_active),
    .divisor_fraction(s.fraction_active),
    .tick(baud_tick)
  );

  // ---------------------------------------------------------------
  // outputs, all from flip-flops
  // ---------------------------------------------------------------
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign queue_enable = s.queue_enable;
  assign line_control_strobe = s.strobe;
  assign divisor_whole_active = s.whole_active;
  assign divisor_fraction_active = s.fraction_active;

endmodule : uart_flags_and_baud_divisor

// file: uart_flags_and_baud_divisor_bench.sv
// self-checking bench for the flag and baud divisor block
`timescale 1ns/1ns
module uart_flags_and_baud_divisor_bench;
  import uart_flags_pkg::*;
  localparam int depth = 16;
  localparam int lw = 5;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, baud_tick;
  logic queue_enable, line_control_strobe;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] divisor_whole_active;
  logic [5:0] divisor_fraction_active;
  logic [lw-1:0] tx_level, rx_level, set_tx = '0, set_rx = '0;
  logic tx_shift_active, rx_char_active, set_shift = 1'b0, set_rxc = 1'b0;
  logic [31:0] seed = 32'hF1AC24D3;
  logic [31:0] exp_rd[$];
  logic [1:0] exp_rr[$], exp_br[$];
  int num_errors = 0, n_checks = 0, cycles = 0, strobes = 0;

  always #5 clk = ~clk;

  uart_flags_and_baud_divisor #(.QUEUE_DEPTH(depth))
    u_uart_flags_and_baud_divisor
    (.clk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .tx_level, .rx_level, .tx_shift_active,
    .rx_char_active, .queue_enable, .line_control_strobe,
    .divisor_whole_active, .divisor_fraction_active, .baud_tick);

  serial_side_model #(.LEVEL_W(lw)) u_serial_side_model (.clk, .rstn,
    .set_tx, .set_rx, .set_shift, .set_rxc, .tx_level, .rx_level,
    .tx_shift_active, .rx_char_active);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // one-byte holding registers count as full at a single entry
  function automatic logic [31:0] flag_word(input logic [lw-1:0] t,
    input logic [lw-1:0] r, input logic sh, input logic q);
    logic [31:0] w;
    logic [lw-1:0] top;
    w = 32'h00000000;
    top = q ? lw'(depth) : lw'(1);
    w[tx_empty_bit] = (t == '0);
    w[rx_full_bit] = (r >= top);
    w[tx_full_bit] = (t >= top);
    w[rx_empty_bit] = (r == '0);
    w[busy_bit] = (t != '0) || sh;
    return w;
  endfunction : flag_word

  task automatic check_word(input string what, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : check_word

  task automatic check_resp(input string what, input logic [1:0] e,
    input logic [1:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : check_resp

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // address and data offered together, each dropped once taken
  task automatic bus_write(input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [1:0] r);
    @(posedge clk);
    exp_br.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] r);
    @(posedge clk);
    exp_rd.push_back(d);
    exp_rr.push_back(r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask : bus_read

  task automatic tick_gap(input int want);
    int n;
    n = 0;
    do @(posedge clk); while (!baud_tick);
    do begin
      @(posedge clk);
      n++;
    end while (!baud_tick);
    check_word("tick gap", want, n);
  endtask : tick_gap

  // answer watcher and hang guard; the run needs a few hundred cycles
  always @(posedge clk) begin
    if (bvalid && bready) begin
      check_resp("bresp", exp_br.pop_front(), bresp);
    end
    if (rvalid && rready) begin
      check_resp("rresp", exp_rr.pop_front(), rresp);
      check_word("rdata", exp_rd.pop_front(), rdata);
    end
    // each strobe pulse stands one cycle, so it is counted once
    if (line_control_strobe) strobes++;
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [lw-1:0] t, r;
    logic sh;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    bus_read(line_flags_offset, 32'h00000090, resp_okay);
    bus_read(divisor_whole_offset, 32'h00000000, resp_okay);
    bus_read(divisor_fraction_offset, 32'h00000000, resp_okay);
    $display("test reset values done");
    // both modes, boundary then random occupancy
    for (int m = 0; m < 2; m++) begin
      bus_write(line_control_offset, {27'h0, m[0], 4'h0}, 4'hF, resp_okay);
      check_word("queue mode", {31'h0, m[0]}, {31'h0, queue_enable});
      bus_read(line_control_offset, {27'h0, m[0], 4'h0}, resp_okay);
      for (int i = 0; i < 6; i++) begin
        seed = lfsr(seed);
        t = (i == 0) ? lw'(depth) : (i == 3) ? lw'(1) : lw'(seed[7:0] % 17);
        r = (i == 1) ? lw'(depth) : (i == 2) ? lw'(0) : lw'(seed[15:8] % 17);
        sh = seed[16] && i != 0;
        set_tx <= t;
        set_rx <= r;
        set_shift <= sh;
        repeat (4) @(posedge clk);
        bus_read(line_flags_offset, flag_word(t, r, sh, m[0]), resp_okay);
      end
    end
    $display("test flags done");
    set_tx <= '0;
    set_rx <= '0;
    set_shift <= 1'b0;
    bus_write(line_flags_offset, 32'hFFFFFFFF, 4'hF, resp_okay);
    bus_read(line_flags_offset, 32'h00000090, resp_okay);
    bus_write(12'h030, 32'h00000001, 4'hF, resp_slverr);
    bus_read(12'h030, read_zero, resp_slverr);
    bus_write(divisor_whole_offset, 32'hFFFF1234, 4'hF, resp_okay);
    bus_write(divisor_whole_offset, 32'h0000ABCD, 4'h1, resp_okay);
    bus_read(divisor_whole_offset, 32'h000012CD, resp_okay);
    bus_write(divisor_fraction_offset, 32'hFFFFFFFF, 4'hF, resp_okay);
    bus_read(divisor_fraction_offset, 32'h0000003F, resp_okay);
    $display("test register access done");
    // hand-over held off by a character going out, then coming in
    bus_write(divisor_whole_offset, 32'h00000007, 4'hF, resp_okay);
    bus_write(divisor_fraction_offset, 32'h00000000, 4'hF, resp_okay);
    set_shift <= 1'b1;
    bus_write(line_control_offset, 32'h00000000, 4'hF, resp_okay);
    set_shift <= 1'b0;
    set_rxc <= 1'b1;
    repeat (8) @(posedge clk);
    check_word("whole held", 32'h0, {16'h0, divisor_whole_active});
    set_rxc <= 1'b0;
    repeat (4) @(posedge clk);
    check_word("whole taken", 32'h7, {16'h0, divisor_whole_active});
    bus_write(divisor_whole_offset, 32'h00000003, 4'hF, resp_okay);
    repeat (6) @(posedge clk);
    check_word("no strobe", 32'h7, {16'h0, divisor_whole_active});
    tick_gap(7);
    bus_write(divisor_whole_offset, 32'h00000000, 4'hF, resp_okay);
    bus_write(divisor_fraction_offset, 32'h00000020, 4'hF, resp_okay);
    bus_write(line_control_offset, 32'h00000000, 4'hF, resp_okay);
    repeat (3) @(posedge clk);
    check_word("frac taken", 32'h20, {26'h0, divisor_fraction_active});
    tick_gap(1);
    check_word("strobes", 32'h00000004, strobes);
    $display("test divisor hand-over done");
    print_verdict();
  end
endmodule : uart_flags_and_baud_divisor_bench

// file: uart_flags_and_baud_divisor_properties.sv
// port assertions for the flag and baud divisor block
`timescale 1ns/1ns
module uart_flags_and_baud_divisor_properties
  import uart_flags_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic tx_shift_active,
  input wire logic rx_char_active,
  input wire logic line_control_strobe,
  input wire logic [15:0] divisor_whole_active,
  input wire logic [5:0] divisor_fraction_active,
  input wire logic baud_tick
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);
  // ---------------------------------------------------------------
  // bus answers
  // ---------------------------------------------------------------
  write_answer_a: assert property (
    awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write answer not two cycles after the request");
  resp_hold_a: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped before it was taken");
  read_answer_a: assert property (
    arvalid && arready |=> rvalid)
    else $error("read answer not one cycle after the request");
  read_hold_a: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data moved before it was taken");
  read_busy_a: assert property (
    rvalid |-> !arready)
    else $error("read address taken while an answer is pending");
  // ---------------------------------------------------------------
  // divisor hand-over and divider
  // ---------------------------------------------------------------
  // a character in flight either way must finish on the old rate
  whole_wait_a: assert property (
    $changed(divisor_whole_active)
    |-> !$past(tx_shift_active) && !$past(rx_char_active))
    else $error("whole divisor applied during a character");
  frac_wait_a: assert property (
    $changed(divisor_fraction_active)
    |-> !$past(tx_shift_active) && !$past(rx_char_active))
    else $error("fraction divisor applied during a character");
  unity_tick_a: assert property (
    $past(rstn) && divisor_whole_active == 16'h0000
    && $past(divisor_whole_active) == 16'h0000 |-> baud_tick)
    else $error("zero divisor does not tick every cycle");
  tick_gap_a: assert property (
    baud_tick && divisor_whole_active > 16'h0001
    && $stable(divisor_whole_active)
    |=> !baud_tick || $changed(divisor_whole_active))
    else $error("divider ticks twice in a row");
  strobe_pulse_a: assert property (
    line_control_strobe |=> !line_control_strobe)
    else $error("line control strobe longer than one cycle");
  strobe_answer_a: assert property (
    line_control_strobe |-> bvalid)
    else $error("line control strobe without a write answer");
endmodule : uart_flags_and_baud_divisor_properties

bind uart_flags_and_baud_divisor uart_flags_and_baud_divisor_properties
  u_props (.clk(clk), .rstn(rstn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .tx_shift_active(tx_shift_active),
  .rx_char_active(rx_char_active),
  .line_control_strobe(line_control_strobe),
  .divisor_whole_active(divisor_whole_active),
  .divisor_fraction_active(divisor_fraction_active),
  .baud_tick(baud_tick));

// file: uart_flags_pkg.sv
// constants shared by the flag and baud divisor block
package uart_flags_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int addr_width = 12;
  localparam logic [11:0] line_flags_offset = 12'h018;
  localparam logic [11:0] divisor_whole_offset = 12'h024;
  localparam logic [11:0] divisor_fraction_offset = 12'h028;
  localparam logic [11:0] line_control_offset = 12'h02C;
  localparam logic [1:0] word_align_bits = 2'h0;

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int tx_empty_bit = 7;
  localparam int rx_full_bit = 6;
  localparam int tx_full_bit = 5;
  localparam int rx_empty_bit = 4;
  localparam int busy_bit = 3;
  localparam int queue_enable_bit = 4;
  localparam int whole_width = 16;
  localparam int fraction_width = 6;
  localparam int byte_width = 8;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] divisor_whole_reset = 16'h0000;
  localparam logic [5:0] divisor_fraction_reset = 6'h00;
  localparam logic tx_empty_reset = 1'b1;
  localparam logic rx_full_reset = 1'b0;
  localparam logic tx_full_reset = 1'b0;
  localparam logic rx_empty_reset = 1'b1;
  localparam logic busy_reset = 1'b0;
  localparam logic queue_enable_reset = 1'b0;

  // ---------------------------------------------------------------
  // bus answers and queue depth
  // ---------------------------------------------------------------
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  localparam logic [31:0] read_zero = 32'h00000000;
  localparam int default_queue_depth = 16;

endpackage : uart_flags_pkg
